// File: logic/dac_ctrl_pkg.sv
// Constants and shared types for the serial and pulse counter interface
package dac_ctrl_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_RESET = 8'h80;
    localparam logic [7:0] CNT_TOP = 8'hFC;
    localparam logic [7:0] CNT_MIN = 8'h00;
    localparam logic [7:0] CNT_STEP = 8'h04;
    localparam logic [7:0] LOW_MASK = 8'hFC;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [7:0] STARTUP_CYCLES = 8'h04;

    typedef enum logic [1:0] {
        MODE_SPI,
        MODE_INC_ONLY,
        MODE_UP_DOWN
    } count_mode_t;
endpackage

// File: logic/pin_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic init_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;

    // Stage one feeds only stage two; a change counts once stages two and three agree
    always_comb begin
        sync_d = {sync_q[1:0], pin_i};
        level_d = level_q;
        if (sync_q[2] == sync_q[1]) begin
            level_d = sync_q[2];
        end
        rise_d = level_d & ~level_q;
        fall_d = ~level_d & level_q;
        // Startup window: level follows the pin with no edges, so reset never fakes one
        if (init_i) begin
            level_d = sync_q[2];
            rise_d = 1'b0;
            fall_d = 1'b0;
        end
    end

    // Filtered level resets high for every instance; the startup window then loads the pin level
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_q <= dac_ctrl_pkg::SYNC_RESET;
            level_q <= 1'b1;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign level_o = level_q;
    assign rise_o = rise_q;
    assign fall_o = fall_q;
endmodule
`default_nettype wire

// File: logic/step_counter.sv
// Six-bit step arithmetic for the pulse counting modes
`timescale 1ns/1ps
`default_nettype none
module step_counter (
    input wire logic [7:0] value_i,
    input wire logic up_i,
    input wire logic wrap_i,
    output logic [7:0] value_o
);
    logic [7:0] base;

    // Low bits dropped first so stale SPI bits never leak into the count
    always_comb begin
        base = value_i & dac_ctrl_pkg::LOW_MASK;
        value_o = base;
        if (up_i) begin
            if (base == dac_ctrl_pkg::CNT_TOP) begin
                value_o = wrap_i ? dac_ctrl_pkg::CNT_MIN : base;
            end else begin
                value_o = base + dac_ctrl_pkg::CNT_STEP;
            end
        end else begin
            if (base != dac_ctrl_pkg::CNT_MIN) begin
                value_o = base - dac_ctrl_pkg::CNT_STEP;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/dac_counter_serial_pulse_iface.sv
// Serial and pulse controlled DAC counter, top level
`timescale 1ns/1ps
`default_nettype none
module dac_counter_serial_pulse_iface (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic shift_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic count_direction_in_i,
    input wire logic shutdown_n_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic [7:0] dac_code_o,
    output logic spi_mode_o,
    output logic up_down_mode_o
);
    ////////////////////////////////////////////////////////////////////////
    // Startup window: straps captured after synchronisers have filled
    logic [7:0] start_cnt_q;
    logic [7:0] start_cnt_d;
    logic starting;

    assign starting = (start_cnt_q != dac_ctrl_pkg::STARTUP_CYCLES);

    // Counts a few cycles after reset release, then stops
    always_comb begin
        start_cnt_d = start_cnt_q;
        if (starting) begin
            start_cnt_d = start_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_cnt_q <= 8'h00;
        end else begin
            start_cnt_q <= start_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic sclk_rise;
    logic sclk_fall;
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic dir_lvl;

    pin_sync u_sync_sclk (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(shift_clk_i),
        .init_i(starting),
        .level_o(),
        .rise_o(sclk_rise),
        .fall_o(sclk_fall)
    );

    pin_sync u_sync_cs (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(chip_sel_n_i),
        .init_i(starting),
        .level_o(cs_lvl),
        .rise_o(cs_rise),
        .fall_o(cs_fall)
    );

    pin_sync u_sync_dir (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(count_direction_in_i),
        .init_i(starting),
        .level_o(dir_lvl),
        .rise_o(),
        .fall_o()
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky mode flags; only power-up reset clears them
    logic spi_q;
    logic spi_d;
    logic updn_q;
    logic updn_d;
    logic strap_done_q;
    logic strap_done_d;

    // The strap is read from the synchronised level once the window closes
    always_comb begin
        spi_q_hold:
        begin
            spi_d = spi_q;
            updn_d = updn_q;
            strap_done_d = strap_done_q;
            if (!starting) begin
                strap_done_d = 1'b1;
                if (!strap_done_q) begin
                    spi_d = ~cs_lvl;
                    updn_d = cs_lvl & ~dir_lvl;
                end else begin
                    if (!cs_lvl) begin
                        spi_d = 1'b1;
                    end
                    if (!spi_q && !dir_lvl) begin
                        updn_d = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_q <= 1'b0;
            updn_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else begin
            spi_q <= spi_d;
            updn_q <= updn_d;
            strap_done_q <= strap_done_d;
        end
    end

    dac_ctrl_pkg::count_mode_t mode;

    // Mode decode; SPI outranks the pulse modes once chosen
    // SPI is taken from the next flag value, up/down from the current one, so the very first select fall
    // already opens a frame instead of being seen as a pulse-mode event
    always_comb begin
        if (spi_d) begin
            mode = dac_ctrl_pkg::MODE_SPI;
        end else if (updn_q) begin
            mode = dac_ctrl_pkg::MODE_UP_DOWN;
        end else begin
            mode = dac_ctrl_pkg::MODE_INC_ONLY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, shift register and serial output
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] shin_q;
    logic [7:0] shin_d;
    logic [7:0] shout_q;
    logic [7:0] shout_d;
    logic [3:0] bits_q;
    logic [3:0] bits_d;
    logic active_q;
    logic active_d;
    logic sout_q;
    logic sout_d;
    logic [7:0] step_val;
    logic strapped;

    assign strapped = strap_done_q & ~starting;

    step_counter u_step (
        .value_i(cnt_q),
        .up_i(mode == dac_ctrl_pkg::MODE_INC_ONLY ? 1'b1 : dir_lvl),
        .wrap_i(mode == dac_ctrl_pkg::MODE_INC_ONLY),
        .value_o(step_val)
    );

    // Shutdown is not consulted: the counter simply keeps its value
    always_comb begin
        cnt_d = cnt_q;
        shin_d = shin_q;
        shout_d = shout_q;
        bits_d = bits_q;
        active_d = active_q;
        sout_d = sout_q;
        case (mode)
            dac_ctrl_pkg::MODE_SPI: begin
                if (strapped && cs_fall) begin
                    active_d = 1'b1;
                    shout_d = cnt_q;
                    sout_d = cnt_q[7];
                    bits_d = dac_ctrl_pkg::BIT_COUNT_RESET;
                end else if (active_q && cs_rise) begin
                    active_d = 1'b0;
                    if (bits_q >= dac_ctrl_pkg::BITS_PER_WORD) begin
                        cnt_d = shin_q;
                    end
                end else if (active_q && sclk_rise) begin
                    shin_d = {shin_q[6:0], dir_lvl};
                    if (bits_q < dac_ctrl_pkg::BITS_PER_WORD) begin
                        bits_d = bits_q + 4'h1;
                    end
                end else if (active_q && sclk_fall) begin
                    shout_d = {shout_q[6:0], 1'b0};
                    sout_d = shout_q[6];
                end
            end
            dac_ctrl_pkg::MODE_INC_ONLY,
            dac_ctrl_pkg::MODE_UP_DOWN: begin
                active_d = 1'b0;
                if (strapped && sclk_rise) begin
                    cnt_d = step_val;
                end else begin
                    cnt_d = cnt_q & dac_ctrl_pkg::LOW_MASK;
                end
            end
            default: begin
                active_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= dac_ctrl_pkg::CNT_RESET;
            shin_q <= 8'h00;
            shout_q <= 8'h00;
            bits_q <= dac_ctrl_pkg::BIT_COUNT_RESET;
            active_q <= 1'b0;
            sout_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            shin_q <= shin_d;
            shout_q <= shout_d;
            bits_q <= bits_d;
            active_q <= active_d;
            sout_q <= sout_d;
        end
    end

    assign serial_out_o = sout_q;
    assign serial_out_oe_o = active_q;
    assign dac_code_o = cnt_q;
    assign spi_mode_o = spi_q;
    assign up_down_mode_o = updn_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_RESET_MID: assert property (@(posedge clk_sys_i) $rose(rst_n_i) |-> cnt_q == 8'h80)
        else $error("Counter not mid-scale after reset");
    AST_SPI_STICKY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(spi_q) |-> spi_q)
        else $error("SPI mode flag dropped");
    AST_UPDN_STICKY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(updn_q) |-> updn_q)
        else $error("Up/down flag dropped");
    AST_OE_ON_FALL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (spi_q && strapped && cs_fall) |=> serial_out_oe_o)
        else $error("Serial output not enabled after select fall");
    AST_OE_OFF_RISE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (active_q && cs_rise && !cs_fall) |=> !serial_out_oe_o)
        else $error("Serial output not released on select rise");
    AST_LOAD_BYTE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (spi_q && active_q && cs_rise && bits_q == 4'h8) |=> cnt_q == $past(shin_q))
        else $error("Shifted byte not loaded");
    AST_LOW_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!spi_q && strapped && $past(strapped)) |-> cnt_q[1:0] == 2'b00)
        else $error("Low bits nonzero in pulse mode");
    AST_INC_WRAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!spi_q && !updn_q && strapped && sclk_rise && cnt_q == 8'hFC) |=> cnt_q == 8'h00)
        else $error("Increment-only did not wrap");
    AST_UP_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (updn_q && !spi_q && strapped && sclk_rise && dir_lvl && cnt_q == 8'hFC) |=> cnt_q == 8'hFC)
        else $error("Up/down passed top");
    AST_DOWN_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (updn_q && !spi_q && strapped && sclk_rise && !dir_lvl && cnt_q == 8'h00) |=> cnt_q == 8'h00)
        else $error("Up/down passed bottom");
    AST_INC_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!spi_q && !updn_q && strapped && sclk_rise && cnt_q == 8'h80) |=> cnt_q == 8'h84)
        else $error("Increment step wrong");
    // Straps, frame bits and step size; shutdown must leave the count alone
    AST_STRAP_SPI: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!strap_done_q && !starting) |=> spi_q == !$past(cs_lvl))
        else $error("Select strap not latched");
    AST_STRAP_UPDN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!strap_done_q && !starting) |=> updn_q == ($past(cs_lvl) && !$past(dir_lvl)))
        else $error("Direction strap not latched");
    AST_SPI_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (strap_done_q && !starting && !cs_lvl) |=> spi_q)
        else $error("Select low did not enter SPI mode");
    AST_OE_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !spi_q |-> !serial_out_oe_o)
        else $error("Serial output enabled in pulse mode");
    AST_DOUT_FIRST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (spi_d && strapped && cs_fall) |=> serial_out_o == $past(cnt_q[7]))
        else $error("First readback bit wrong");
    AST_DOUT_SHIFT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (active_q && sclk_fall && !cs_fall && !cs_rise) |=> serial_out_o == $past(shout_q[6]))
        else $error("Readback bit not advanced");
    AST_DIN_SAMPLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (active_q && sclk_rise && !cs_fall && !cs_rise) |=> shin_q == {$past(shin_q[6:0]), $past(dir_lvl)})
        else $error("Input bit not shifted in");
    AST_SHORT_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (active_q && cs_rise && bits_q < 4'h8) |=> cnt_q == $past(cnt_q))
        else $error("Short frame changed the counter");
    AST_UP_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (updn_q && !spi_d && strapped && sclk_rise && dir_lvl && cnt_q != 8'hFC) |=> cnt_q == $past(cnt_q) + 8'h04)
        else $error("Up step wrong");
    AST_DOWN_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (updn_q && !spi_d && strapped && sclk_rise && !dir_lvl && cnt_q != 8'h00) |=> cnt_q == $past(cnt_q) - 8'h04)
        else $error("Down step wrong");
    AST_SHUTDOWN_N_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!shutdown_n_i && !sclk_rise && !cs_rise) |=> cnt_q == $past(cnt_q))
        else $error("Counter moved during shutdown");
endmodule
`default_nettype wire

// File: sim/serial_host_model.sv
// Host processor model driving the shift clock, chip select and data pins
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic clk_sys_i,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_i,
    output logic shift_clk_o,
    output logic chip_sel_n_o,
    output logic count_direction_in_o
);
    // Idle pins; the shift clock stands still outside frames and pulses
    initial begin
        shift_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        count_direction_in_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin moves land on falling system edges, away from the sampling edge
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // Power-up levels of chip select and data
    task automatic strap(input logic cs_n, input logic dir);
        chip_sel_n_o = cs_n;
        count_direction_in_o = dir;
    endtask

    // Count pulses; direction set up a half period ahead of the first rise and held for the rest
    task automatic pulse(input logic dir, input int n);
        count_direction_in_o = dir;
        hold(10);
        for (int i = 0; i < n; i++) begin
            shift_clk_o = 1'b1;
            hold(10);
            shift_clk_o = 1'b0;
            hold(10);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One frame; read bits count only while the output is enabled
    task automatic xfer(input logic [7:0] wr, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        chip_sel_n_o = 1'b0;
        hold(10);
        for (int i = 0; i < nbits; i++) begin
            count_direction_in_o = wr[7 - i];
            hold(10);
            rd = {rd[6:0], (serial_out_oe_i === 1'b1) ? serial_out_i : 1'bx};
            shift_clk_o = 1'b1;
            hold(10);
            shift_clk_o = 1'b0;
        end
        hold(10);
        chip_sel_n_o = 1'b1;
        // Deselected data line must not keep its last value
        count_direction_in_o = ~count_direction_in_o;
        hold(10);
    endtask
endmodule
`default_nettype wire

// File: sim/dac_counter_serial_pulse_iface_tb_top.sv
// Self-checking bench for the serial and pulse DAC counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dac_counter_serial_pulse_iface_tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic shutdown_n_i = 1'b1;
    logic shift_clk, chip_sel_n, dir_in, sout, sout_oe, spi_mode, up_down_mode;
    logic [7:0] dac_code;
    logic [7:0] rd;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    // 250 MHz system clock
    always #2 clk_sys_i = ~clk_sys_i;

    dac_counter_serial_pulse_iface uut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk), .chip_sel_n_i(chip_sel_n),
        .count_direction_in_i(dir_in), .shutdown_n_i(shutdown_n_i), .serial_out_o(sout),
        .serial_out_oe_o(sout_oe), .dac_code_o(dac_code), .spi_mode_o(spi_mode),
        .up_down_mode_o(up_down_mode)
    );

    serial_host_model host (
        .clk_sys_i(clk_sys_i), .serial_out_i(sout), .serial_out_oe_i(sout_oe), .shift_clk_o(shift_clk),
        .chip_sel_n_o(chip_sel_n), .count_direction_in_o(dir_in)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Whole run needs well under 12k cycles; a hang ends here
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            final_report();
        end
    end

    // Power-up with strap levels held well past the sampling window
    task automatic power_up(input logic cs_n, input logic dir);
        host.strap(cs_n, dir);
        rst_n_i = 1'b0;
        host.hold(6);
        rst_n_i = 1'b1;
        host.hold(12);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // Increment-only pulse mode
        power_up(1'b1, 1'b1);
        `CHK("dac_code", 8'h80, dac_code)
        `CHK("spi_mode", 1'b0, spi_mode)
        `CHK("up_down_mode", 1'b0, up_down_mode)
        host.pulse(1'b1, 2);
        `CHK("dac_code", 8'h88, dac_code)
        `CHK("serial_out_oe", 1'b0, sout_oe)
        host.pulse(1'b1, 29);
        `CHK("dac_code", 8'hFC, dac_code)
        host.pulse(1'b1, 1);
        `CHK("dac_code", 8'h00, dac_code)
        host.pulse(1'b1, 63);
        `CHK("dac_code", 8'hFC, dac_code)
        `CHK("up_down_mode", 1'b0, up_down_mode)
        // Up/down pulse mode, entered by one low on the direction pin
        power_up(1'b1, 1'b1);
        host.pulse(1'b0, 1);
        `CHK("up_down_mode", 1'b1, up_down_mode)
        `CHK("dac_code", 8'h7C, dac_code)
        host.pulse(1'b0, 40);
        `CHK("dac_code", 8'h00, dac_code)
        host.pulse(1'b1, 1);
        `CHK("dac_code", 8'h04, dac_code)
        `CHK("up_down_mode", 1'b1, up_down_mode)
        host.pulse(1'b1, 70);
        `CHK("dac_code", 8'hFC, dac_code)
        // SPI mode with readback of the old value
        power_up(1'b1, 1'b1);
        host.xfer(8'hA5, 8, rd);
        `CHK("read_back", 8'h80, rd)
        `CHK("dac_code", 8'hA5, dac_code)
        `CHK("spi_mode", 1'b1, spi_mode)
        `CHK("serial_out_oe", 1'b0, sout_oe)
        host.xfer(8'h3D, 8, rd);
        `CHK("read_back", 8'hA5, rd)
        `CHK("dac_code", 8'h3D, dac_code)
        // Short frame is refused
        host.xfer(8'hFF, 4, rd);
        `CHK("read_back", 8'h03, rd)
        `CHK("dac_code", 8'h3D, dac_code)
        // Shutdown keeps the setting
        shutdown_n_i = 1'b0;
        host.hold(20);
        `CHK("dac_code", 8'h3D, dac_code)
        shutdown_n_i = 1'b1;
        host.hold(20);
        `CHK("dac_code", 8'h3D, dac_code)
        // Clock pulses outside a frame must not count once in SPI mode
        host.pulse(1'b1, 3);
        `CHK("dac_code", 8'h3D, dac_code)
        `CHK("spi_mode", 1'b1, spi_mode)
        // Low straps at power-up: direction low picks up/down, select low picks SPI
        power_up(1'b1, 1'b0);
        `CHK("up_down_mode", 1'b1, up_down_mode)
        `CHK("spi_mode", 1'b0, spi_mode)
        power_up(1'b0, 1'b1);
        `CHK("spi_mode", 1'b1, spi_mode)
        `CHK("up_down_mode", 1'b0, up_down_mode)
        // Select must rise before a frame can open with a fresh fall
        host.strap(1'b1, 1'b1);
        host.hold(10);
        host.xfer(8'h5A, 8, rd);
        `CHK("read_back", 8'h80, rd)
        `CHK("dac_code", 8'h5A, dac_code)
        final_report();
    end
endmodule
`undef CHK
`default_nettype wire
